// [rtl/gpt_timer_pair.sv]
`timescale 1ns/1ps
`default_nettype none
`include "gpt_defs.svh"
module gpt_timer_pair (
	input wire logic clk_i, // peripheral bus clock, 125 MHz
	input wire logic rst_i, // synchronous reset, active high
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write enable
	input wire logic [5:0] wb_adr_i, // wishbone byte address
	input wire logic [3:0] wb_sel_i, // wishbone byte selects
	input wire logic [31:0] wb_dat_i, // wishbone write data
	output logic [31:0] wb_dat_o, // wishbone read data
	output logic wb_ack_o, // wishbone acknowledge
	input wire logic lower_pin_i, // lower timer clock/gate pin
	input wire logic upper_pin_i, // upper timer clock/gate pin
	output logic lower_event_o, // lower timer event flag and enable
	output logic upper_event_o // upper timer event flag and enable
);
	// the pair is one lower-controlling unit; no other pairing exists
	logic [15:0] ctl_lo_reg, ctl_hi_reg;
	logic [15:0] cnt_lo_reg, cnt_hi_reg, per_lo_reg, per_hi_reg;
	logic [1:0] flag_reg, en_reg;
	logic [1:0] lo_sync_reg, hi_sync_reg;
	logic lo_prev_reg, hi_prev_reg;
	logic [7:0] ps_lo_reg, ps_hi_reg;
	logic gate_lo_reg, gate_hi_reg;
	logic ack_reg;
	logic [31:0] dat_reg;
	logic lo_event, hi_event;
	logic [1:0] ev_set;

	wire logic acc = wb_cyc_i & wb_stb_i & ~ack_reg;
	wire logic wr = acc & wb_we_i;
	wire logic pair = ctl_lo_reg[`GPT_B_PAIR];
	wire logic lo_on = ctl_lo_reg[`GPT_B_ON];
	wire logic hi_on = ctl_hi_reg[`GPT_B_ON] | (pair & lo_on);
	wire logic wr_cnt_lo = wr & (wb_adr_i == `GPT_A_CNT_LO);
	wire logic wr_cnt_hi = wr & (wb_adr_i == `GPT_A_CNT_HI);
	wire logic wr_per_lo = wr & (wb_adr_i == `GPT_A_PER_LO);
	wire logic wr_per_hi = wr & (wb_adr_i == `GPT_A_PER_HI);
	wire logic wr_ctl_lo = wr & (wb_adr_i == `GPT_A_CTL_LO);
	wire logic wr_ctl_hi = wr & (wb_adr_i == `GPT_A_CTL_HI);
	wire logic wr_flag = wr & (wb_adr_i == `GPT_A_FLAG);

	function automatic logic [7:0] ps_last(input logic [2:0] code);
		// terminal count of the prescaler for divide 1..256
		case (code)
			3'b000: ps_last = `GPT_PS_LAST_D1;
			3'b001: ps_last = `GPT_PS_LAST_D2;
			3'b010: ps_last = `GPT_PS_LAST_D4;
			3'b011: ps_last = `GPT_PS_LAST_D8;
			3'b100: ps_last = `GPT_PS_LAST_D16;
			3'b101: ps_last = `GPT_PS_LAST_D32;
			3'b110: ps_last = `GPT_PS_LAST_D64;
			default: ps_last = `GPT_PS_MAX;
		endcase
	endfunction

	// gate bit stays stored; it is only hidden while the external source is chosen
	function automatic logic [15:0] ctl_rd(input logic [15:0] c);
		ctl_rd = c;
		if (c[`GPT_B_TCS]) begin
			ctl_rd[`GPT_B_GATE] = 1'b0;
		end
	endfunction

	function automatic gpt_pkg::gpt_src_e src_of(input logic [15:0] c);
		if (c[`GPT_B_TCS]) begin
			src_of = gpt_pkg::GPT_SRC_EXT;
		end else if (c[`GPT_B_GATE]) begin
			src_of = gpt_pkg::GPT_SRC_GATE;
		end else begin
			src_of = gpt_pkg::GPT_SRC_INT;
		end
	endfunction

	// pins are asynchronous to the bus clock; the first stage feeds only the second
	// an edge is seen two clocks after the pin moves
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lo_sync_reg <= 2'b00;
			hi_sync_reg <= 2'b00;
			lo_prev_reg <= 1'b0;
			hi_prev_reg <= 1'b0;
		end else begin
			lo_sync_reg <= {lo_sync_reg[0], lower_pin_i};
			hi_sync_reg <= {hi_sync_reg[0], upper_pin_i};
			lo_prev_reg <= lo_sync_reg[1];
			hi_prev_reg <= hi_sync_reg[1];
		end
	end

	wire logic lo_rise = lo_sync_reg[1] & ~lo_prev_reg;
	wire logic lo_fall = ~lo_sync_reg[1] & lo_prev_reg;
	wire logic hi_rise = hi_sync_reg[1] & ~hi_prev_reg;
	wire logic hi_fall = ~hi_sync_reg[1] & hi_prev_reg;

	// in pair mode the upper pin is never looked at
	wire gpt_pkg::gpt_src_e src_lo = src_of(ctl_lo_reg);
	wire gpt_pkg::gpt_src_e src_hi = src_of(ctl_hi_reg);
	// prescaler terminal values for the selected divide ratio
	wire logic [7:0] last_lo = ps_last(ctl_lo_reg[`GPT_B_PS_HI:`GPT_B_PS_LO]);
	wire logic [7:0] last_hi = ps_last(ctl_hi_reg[`GPT_B_PS_HI:`GPT_B_PS_LO]);

	// gate windows: open on rising edge, close on falling edge
	always_ff @(posedge clk_i) begin
		if (rst_i || !lo_on) begin
			gate_lo_reg <= 1'b0;
		end else if (lo_rise) begin
			gate_lo_reg <= 1'b1;
		end else if (lo_fall) begin
			gate_lo_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		// held shut while paired so a moving upper pin cannot open it
		if (rst_i || !hi_on || pair) begin
			gate_hi_reg <= 1'b0;
		end else if (hi_rise) begin
			gate_hi_reg <= 1'b1;
		end else if (hi_fall) begin
			gate_hi_reg <= 1'b0;
		end
	end

	// raw timer ticks before the prescaler
	// internal source ticks every cycle, gate mode only while the window is open
	wire logic tick_lo = (src_lo == gpt_pkg::GPT_SRC_EXT) ? lo_rise :
		(src_lo == gpt_pkg::GPT_SRC_GATE) ? gate_lo_reg : 1'b1;
	wire logic tick_hi = (src_hi == gpt_pkg::GPT_SRC_EXT) ? hi_rise :
		(src_hi == gpt_pkg::GPT_SRC_GATE) ? gate_hi_reg : 1'b1;

	// prescalers: clear on reset, disable or a write to their own count address
	// external prescaling starts on the first synced edge, with no extra resync delay
	always_ff @(posedge clk_i) begin
		if (rst_i || !lo_on || wr_cnt_lo) begin
			ps_lo_reg <= `GPT_PS_LAST_D1;
		end else if (tick_lo) begin
			ps_lo_reg <= (ps_lo_reg >= last_lo) ?
				`GPT_PS_LAST_D1 : ps_lo_reg + 8'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !hi_on || pair || wr_cnt_hi) begin
			ps_hi_reg <= `GPT_PS_LAST_D1;
		end else if (tick_hi) begin
			ps_hi_reg <= (ps_hi_reg >= last_hi) ?
				`GPT_PS_LAST_D1 : ps_hi_reg + 8'h01;
		end
	end

	wire logic inc_lo = lo_on & tick_lo &
		(ps_lo_reg >= last_lo);
	wire logic inc_hi = hi_on & ~pair & tick_hi &
		(ps_hi_reg >= last_hi);

	wire logic [31:0] cnt32 = {cnt_hi_reg, cnt_lo_reg};
	wire logic [31:0] per32 = {per_hi_reg, per_lo_reg};
	wire logic eq32 = (cnt32 == per32);
	wire logic eq_lo = (cnt_lo_reg == per_lo_reg);
	wire logic eq_hi = (cnt_hi_reg == per_hi_reg);
	// the wrap lands on the tick after the count reaches the period
	wire logic [31:0] nxt32 = eq32 ? `GPT_RST32 : cnt32 + 32'h0000_0001;
	wire logic [15:0] nxt_lo = eq_lo ? `GPT_RST16 : cnt_lo_reg + 16'h0001;
	wire logic [15:0] nxt_hi = eq_hi ? `GPT_RST16 : cnt_hi_reg + 16'h0001;

	// lower half of the count, or the whole low word in pair mode
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_lo_reg <= `GPT_RST16;
		end else if (wr_cnt_lo) begin
			if (wb_sel_i[0]) begin
				cnt_lo_reg[7:0] <= wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				cnt_lo_reg[15:8] <= wb_dat_i[15:8];
			end
		end else if (inc_lo) begin
			cnt_lo_reg <= pair ? nxt32[15:0] : nxt_lo;
		end
	end

	// the upper half takes the high word of a 32-bit lower write in pair mode
	// a direct upper-count write still lands while paired; use the lower address
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_hi_reg <= `GPT_RST16;
		end else if (wr_cnt_lo && pair) begin
			if (wb_sel_i[2]) begin
				cnt_hi_reg[7:0] <= wb_dat_i[23:16];
			end
			if (wb_sel_i[3]) begin
				cnt_hi_reg[15:8] <= wb_dat_i[31:24];
			end
		end else if (wr_cnt_hi) begin
			if (wb_sel_i[0]) begin
				cnt_hi_reg[7:0] <= wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				cnt_hi_reg[15:8] <= wb_dat_i[15:8];
			end
		end else if (pair && inc_lo) begin
			cnt_hi_reg <= nxt32[31:16];
		end else if (inc_hi) begin
			cnt_hi_reg <= nxt_hi;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			per_lo_reg <= `GPT_PER_RST;
			per_hi_reg <= `GPT_PER_RST;
		end else begin
			if (wr_per_lo) begin
				if (wb_sel_i[0]) begin
					per_lo_reg[7:0] <= wb_dat_i[7:0];
				end
				if (wb_sel_i[1]) begin
					per_lo_reg[15:8] <= wb_dat_i[15:8];
				end
				if (pair && wb_sel_i[2]) begin
					per_hi_reg[7:0] <= wb_dat_i[23:16];
				end
				if (pair && wb_sel_i[3]) begin
					per_hi_reg[15:8] <= wb_dat_i[31:24];
				end
			end
			if (wr_per_hi) begin
				if (wb_sel_i[0]) begin
					per_hi_reg[7:0] <= wb_dat_i[7:0];
				end
				if (wb_sel_i[1]) begin
					per_hi_reg[15:8] <= wb_dat_i[15:8];
				end
			end
		end
	end

	// control registers; upper one is locked while paired
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl_lo_reg <= `GPT_RST16;
			ctl_hi_reg <= `GPT_RST16;
		end else begin
			// both low lanes are needed, so a mode never changes half-way
			if (wr_ctl_lo && wb_sel_i[1:0] == 2'b11) begin
				ctl_lo_reg <= wb_dat_i[15:0] & `GPT_CTL_WMASK;
			end
			if (wr_ctl_hi && wb_sel_i[1:0] == 2'b11 && !pair) begin
				ctl_hi_reg <= wb_dat_i[15:0] & `GPT_CTL_HI_WMASK;
			end
		end
	end

	// match events happen on the tick at which the count equals the period;
	// gated modes only ever report the gate falling edge
	// a gate event needs an open window; a pin falling while disabled stays silent
	always_comb begin
		lo_event = 1'b0;
		hi_event = 1'b0;
		if (pair) begin
			if (src_lo == gpt_pkg::GPT_SRC_GATE) begin
				hi_event = lo_on & lo_fall & gate_lo_reg;
			end else begin
				hi_event = inc_lo & eq32;
			end
		end else begin
			if (src_lo == gpt_pkg::GPT_SRC_GATE) begin
				lo_event = lo_on & lo_fall & gate_lo_reg;
			end else begin
				lo_event = inc_lo & eq_lo;
			end
			if (src_hi == gpt_pkg::GPT_SRC_GATE) begin
				hi_event = hi_on & hi_fall & gate_hi_reg;
			end else begin
				hi_event = inc_hi & eq_hi;
			end
		end
	end
	assign ev_set = {hi_event, lo_event};

	// one-cycle registration keeps flag latency well inside the allowed bound;
	// a set in the same cycle as a software clear wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flag_reg <= 2'b00;
			en_reg <= 2'b00;
		end else begin
			if (wr_flag && wb_sel_i[0]) begin
				flag_reg <= (flag_reg & wb_dat_i[1:0]) | ev_set;
			end else begin
				flag_reg <= flag_reg | ev_set;
			end
			if (wr_flag && wb_sel_i[1]) begin
				en_reg <= wb_dat_i[9:8];
			end
		end
	end

	// in pair mode the lower flag and enable are ignored for event output
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lower_event_o <= 1'b0;
			upper_event_o <= 1'b0;
		end else begin
			lower_event_o <= flag_reg[0] & en_reg[0] & ~pair;
			upper_event_o <= flag_reg[1] & en_reg[1];
		end
	end

	// wishbone slave: one wait state, unmapped reads return zero
	// writes land on the request edge; ack rises on that same edge
	// lanes beyond a register's width are ignored, except lanes 2/3 of lower count/period writes in pair mode
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= `GPT_RST32;
		end else begin
			ack_reg <= acc;
			if (acc) begin
				if (wb_adr_i == `GPT_A_CTL_LO) begin
					dat_reg <= {16'h0000, ctl_rd(ctl_lo_reg)};
				end else if (wb_adr_i == `GPT_A_CNT_LO) begin
					dat_reg <= pair ? cnt32 : {16'h0000, cnt_lo_reg};
				end else if (wb_adr_i == `GPT_A_PER_LO) begin
					dat_reg <= pair ? per32 : {16'h0000, per_lo_reg};
				end else if (wb_adr_i == `GPT_A_CTL_HI) begin
					dat_reg <= {16'h0000, ctl_rd(ctl_hi_reg)};
				end else if (wb_adr_i == `GPT_A_CNT_HI) begin
					dat_reg <= {16'h0000, cnt_hi_reg};
				end else if (wb_adr_i == `GPT_A_PER_HI) begin
					dat_reg <= {16'h0000, per_hi_reg};
				end else if (wb_adr_i == `GPT_A_FLAG) begin
					dat_reg <= {22'h00_0000, en_reg, 6'h00, flag_reg};
				end else begin
					dat_reg <= `GPT_RST32;
				end
			end
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
endmodule
`default_nettype wire

// [rtl/gpt_defs.svh]
`ifndef GPT_DEFS_SVH
`define GPT_DEFS_SVH
// word byte offsets on the wishbone bus
`define GPT_A_CTL_LO 6'h00
`define GPT_A_CNT_LO 6'h04
`define GPT_A_PER_LO 6'h08
`define GPT_A_CTL_HI 6'h0C
`define GPT_A_CNT_HI 6'h10
`define GPT_A_PER_HI 6'h14
`define GPT_A_FLAG 6'h18
// control fields
`define GPT_B_ON 15
`define GPT_B_GATE 7
`define GPT_B_PS_HI 6
`define GPT_B_PS_LO 4
`define GPT_B_PAIR 3
`define GPT_B_TCS 1
`define GPT_CTL_WMASK 16'h80FA
`define GPT_CTL_HI_WMASK 16'h80F2
// flag register: bit0 lower timer, bit1 upper timer, bit8/9 enables
`define GPT_B_FLAG_LO 0
`define GPT_B_FLAG_HI 1
`define GPT_B_EN_LO 8
`define GPT_B_EN_HI 9
`define GPT_RST16 16'h0000
`define GPT_RST32 32'h0000_0000
`define GPT_PER_RST 16'hFFFF
// prescaler terminal counts, divide ratio minus one
`define GPT_PS_LAST_D1 8'h00
`define GPT_PS_LAST_D2 8'h01
`define GPT_PS_LAST_D4 8'h03
`define GPT_PS_LAST_D8 8'h07
`define GPT_PS_LAST_D16 8'h0F
`define GPT_PS_LAST_D32 8'h1F
`define GPT_PS_LAST_D64 8'h3F
`define GPT_PS_MAX 8'hFF
`endif

// [rtl/gpt_pkg.sv]
package gpt_pkg;
	typedef enum logic [1:0] {
		GPT_SRC_INT = 2'b00,
		GPT_SRC_GATE = 2'b01,
		GPT_SRC_EXT = 2'b10
	} gpt_src_e;
endpackage

// [tb/gpt_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
module gpt_pin_model (
	input wire logic clk_i, // bus clock
	input wire logic rst_i, // sync reset
	input wire logic gate_i, // gate level
	input wire logic [7:0] burst_i, // pulses to send
	input wire logic load_i, // start a burst
	output logic pin_o // clock or gate pin
);
	logic [7:0] left_reg;
	logic [1:0] ph_reg;
	always_ff @(posedge clk_i) begin
		if (rst_i || load_i) begin
			left_reg <= rst_i ? 8'h00 : burst_i;
		end else if (left_reg != 8'h00 && ph_reg == 2'h3) begin
			left_reg <= left_reg - 8'h01;
		end
		ph_reg <= (left_reg != 8'h00 && !rst_i) ? ph_reg + 2'h1 : 2'h0;
	end
	// clock stands low between bursts, two cycles high and two low inside
	assign pin_o = gate_i | (left_reg != 8'h00 && ph_reg[1]);
endmodule
`default_nettype wire

// [tb/gpt_timer_pair_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
`include "gpt_defs.svh"
module gpt_timer_pair_monitor (
	input wire logic clk_i, // bus clock
	input wire logic rst_i, // sync reset
	input wire logic wb_cyc_i, // cycle
	input wire logic wb_stb_i, // strobe
	input wire logic wb_we_i, // write
	input wire logic [5:0] wb_adr_i, // address
	input wire logic [3:0] wb_sel_i, // lanes
	input wire logic [31:0] wb_dat_i, // write data
	input wire logic [31:0] wb_dat_o, // read data
	input wire logic wb_ack_o, // ack
	input wire logic lower_event_o, // lower event
	input wire logic upper_event_o // upper event
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic req;
	logic pair_reg;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pair_reg <= 1'b0;
		end else if (req && wb_we_i && wb_adr_i == `GPT_A_CTL_LO && &wb_sel_i[1:0]) begin
			pair_reg <= wb_dat_i[`GPT_B_PAIR];
		end
	end
	sequence rd_of(logic [5:0] ad);
		req && !wb_we_i && wb_adr_i == ad;
	endsequence
	sequence ack_then_idle;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	chk_ack_answers: assert property (req |=> ack_then_idle)
		else $error("ack not a single pulse after request");
	chk_ack_needs_req: assert property (!req |=> !wb_ack_o)
		else $error("ack without request");
	chk_rdata_holds: assert property (!req |=> $stable(wb_dat_o))
		else $error("read data moved without access");
	chk_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i > `GPT_A_FLAG
		|=> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
	chk_ctl_reserved: assert property (rd_of(`GPT_A_CTL_LO)
		|=> (wb_dat_o[15:0] & ~`GPT_CTL_WMASK) == 16'h0000) else $error("reserved bits set");
	chk_gate_reads_zero: assert property (rd_of(`GPT_A_CTL_LO)
		|=> !(wb_dat_o[`GPT_B_TCS] && wb_dat_o[`GPT_B_GATE])) else $error("gate bit with ext");
	chk_pair_lower_quiet: assert property (pair_reg && $past(pair_reg) |-> !lower_event_o)
		else $error("lower event in pair mode");
	chk_event_sticky: assert property ($fell(upper_event_o)
		|-> $past(req && wb_we_i) || $past(req && wb_we_i, 2)) else $error("event lost");
endmodule
`default_nettype wire

// [tb/gated_pairable_timer_test.sv]
`timescale 1ns/1ps
`default_nettype none
`include "gpt_defs.svh"
module gated_pairable_timer_test;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, lg = 1'b0, ll = 1'b0, ul = 1'b0;
	logic [5:0] adr = 6'h00;
	logic [3:0] sel = 4'h0;
	logic [7:0] lb = 8'h00, ub = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, a, dat_o, seed = 32'h0000_bd34;
	logic ack, lev, uev, lpin, upin;
	int err_total = 0;
	int comparisons = 0;
	always #4 clk_i = ~clk_i;
	gpt_timer_pair uut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.lower_pin_i(lpin), .upper_pin_i(upin), .lower_event_o(lev), .upper_event_o(uev));
	gpt_pin_model lo_m (.clk_i, .rst_i, .gate_i(lg), .burst_i(lb), .load_i(ll), .pin_o(lpin));
	gpt_pin_model up_m (.clk_i, .rst_i, .gate_i(1'b0), .burst_i(ub), .load_i(ul), .pin_o(upin));
	task automatic tally_and_finish();
		$display("mismatches %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic fail(input string m);
		err_total++;
		$display("[FAIL] %0t %s", $time, m);
	endtask
	task automatic ck(input logic [31:0] g, input logic [31:0] e, input string m);
		comparisons++;
		if (g !== e) fail(m);
	endtask
	task automatic ckr(input logic [31:0] g, input int lo, input int hi, input string m);
		comparisons++;
		if (^g === 1'bx || g < lo || g > hi) fail(m);
	endtask
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic int dv(input int c);
		return (c == 7) ? 256 : (1 << c);
	endfunction
	// entered just after a rising edge; leaves one idle cycle behind
	task automatic bus(input logic w, input logic [5:0] ad, input logic [31:0] d);
		int n;
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= ad; wdat <= d; sel <= 4'hF;
		n = 0;
		do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) begin
			fail("no ack");
			tally_and_finish();
		end else begin
			rdat = dat_o;
			cyc <= 1'b0; stb <= 1'b0;
			@(posedge clk_i);
		end
	endtask
	task automatic wr(input logic [5:0] ad, input logic [31:0] d);
		bus(1'b1, ad, d);
	endtask
	task automatic rd(input logic [5:0] ad);
		bus(1'b0, ad, 32'h0);
	endtask
	task automatic await_ev(input logic up, input int lim);
		int n;
		n = 0;
		while ((up ? uev : lev) !== 1'b1 && n < lim) begin @(posedge clk_i); n++; end
		comparisons++;
		if ((up ? uev : lev) !== 1'b1) begin fail("event missing"); tally_and_finish(); end
	endtask
	initial begin
		int k, c, m;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(`GPT_A_PER_HI);
		ck(rdat, 32'h0000_FFFF, "period reset");
		rd(6'h3C);
		ck(rdat, 32'h0, "unmapped read");
		wr(`GPT_A_CTL_LO, 32'h0082);
		rd(`GPT_A_CTL_LO);
		ck(32'(rdat[7]), 32'h0, "gate bit with ext clock");
		for (c = 0; c < 8; c++) begin
			seed = xs(seed);
			k = 8 + seed[3:0];
			wr(`GPT_A_CTL_LO, 32'(c) << 4);
			wr(`GPT_A_CNT_LO, 32'h0);
			wr(`GPT_A_CTL_LO, 32'h8000 | 32'(c) << 4);
			repeat (k * dv(c)) @(posedge clk_i);
			wr(`GPT_A_CTL_LO, 32'(c) << 4);
			rd(`GPT_A_CNT_LO);
			m = (k * dv(c) + 3) / dv(c);
			ckr(rdat, m - 1, m + 1, "prescaled count");
		end
		wr(`GPT_A_CTL_LO, 32'h0080);
		wr(`GPT_A_CNT_LO, 32'h0);
		wr(`GPT_A_FLAG, 32'h0100);
		wr(`GPT_A_CTL_LO, 32'h8080);
		lg <= 1'b1;
		repeat (20) @(posedge clk_i);
		lg <= 1'b0;
		await_ev(1'b0, 10);
		rd(`GPT_A_CNT_LO);
		a = rdat;
		ckr(a, 18, 22, "gated count");
		repeat (9) @(posedge clk_i);
		rd(`GPT_A_CNT_LO);
		ck(rdat, a, "gated count not frozen");
		wr(`GPT_A_FLAG, 32'h0200);
		wr(`GPT_A_CTL_LO, 32'h0080);
		wr(`GPT_A_CTL_LO, 32'h0008);
		wr(`GPT_A_CNT_LO, 32'h0001_FFF0);
		wr(`GPT_A_PER_LO, 32'h0002_0004);
		rd(`GPT_A_CNT_HI);
		ck(rdat, 32'h1, "upper count half");
		rd(`GPT_A_PER_LO);
		ck(rdat, 32'h0002_0004, "period pair");
		wr(`GPT_A_CTL_LO, 32'h8008);
		await_ev(1'b1, 40);
		rd(`GPT_A_CNT_LO);
		ckr(rdat, 0, 10, "count after match");
		wr(`GPT_A_CTL_HI, 32'h80F2);
		rd(`GPT_A_CTL_HI);
		ck(rdat, 32'h0, "upper control taken in pair mode");
		rd(`GPT_A_CNT_LO);
		a = rdat;
		rd(`GPT_A_CNT_LO);
		ckr(rdat - a, 2, 4, "pair stopped by upper write");
		wr(`GPT_A_CTL_LO, 32'h0008);
		wr(`GPT_A_CTL_LO, 32'h001A);
		wr(`GPT_A_CNT_LO, 32'h0);
		wr(`GPT_A_PER_LO, 32'h4);
		wr(`GPT_A_FLAG, 32'h0200);
		wr(`GPT_A_CTL_LO, 32'h801A);
		seed = xs(seed);
		lb <= 8'h10; ub <= seed[7:0] | 8'h10; ll <= 1'b1; ul <= 1'b1;
		@(posedge clk_i);
		ll <= 1'b0; ul <= 1'b0;
		repeat (80) @(posedge clk_i);
		ck(32'(uev), 32'h1, "external match");
		rd(`GPT_A_CNT_LO);
		ckr(rdat, 0, 3, "external count");
		wr(`GPT_A_CTL_LO, 32'h001A);
		wr(`GPT_A_CTL_LO, 32'h0088);
		wr(`GPT_A_CNT_LO, 32'h0);
		wr(`GPT_A_PER_LO, 32'h3);
		wr(`GPT_A_FLAG, 32'h0200);
		wr(`GPT_A_CTL_LO, 32'h8088);
		lg <= 1'b1;
		repeat (30) @(posedge clk_i);
		ck(32'(uev), 32'h0, "match event while gated");
		lg <= 1'b0;
		await_ev(1'b1, 10);
		rd(`GPT_A_CNT_LO);
		a = rdat;
		ckr(a, 0, 3, "gated pair beyond period");
		rd(`GPT_A_CNT_LO);
		ck(rdat, a, "gated pair not frozen");
		tally_and_finish();
	end
endmodule
bind gpt_timer_pair gpt_timer_pair_monitor mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .lower_event_o,
	.upper_event_o);
`default_nettype wire
